// *** core/ots_consts.vh ***
// Constants for the third output source select register bank
`ifndef OTS_CONSTS_VH
`define OTS_CONSTS_VH

// Register word addresses
`define OTS_ADDR_W 16
`define OTS_DATA_W 16
`define OTS_ADR_LIM2_EN 16'h0400
`define OTS_ADR_LIM3_EN 16'h0401
`define OTS_ADR_CNT_EN 16'h0402
`define OTS_ADR_FLT1_EN 16'h0408
`define OTS_ADR_FLT2_EN 16'h0409
`define OTS_ADR_FRQ_EN 16'h040a
`define OTS_ADR_DO_STATE 16'h0410
`define OTS_ADR_DO_FORCE 16'h0411
`define OTS_ADR_AO_FORCE 16'h0412
`define OTS_ADR_AO_VALUE 16'h0413
`define OTS_ADR_HRS_EN 16'h041f
`define OTS_ADR_CYC_EN 16'h0420

// Source vector bit positions
`define OTS_SRC_N 8
`define OTS_SRC_LIM2 0
`define OTS_SRC_LIM3 1
`define OTS_SRC_CNT 2
`define OTS_SRC_FLT1 3
`define OTS_SRC_FLT2 4
`define OTS_SRC_FRQ 5
`define OTS_SRC_HRS 6
`define OTS_SRC_CYC 7

// Analog value limits (two's complement, percent)
`define OTS_AO_MIN 16'hf831
`define OTS_AO_MAX 16'h270f

// Reset values
`define OTS_RST_EN 8'h00
`define OTS_RST_BIT 1'b0
`define OTS_RST_WORD 16'h0000

`endif

// *** core/ots_route.v ***
// Source routing: OR of enabled internal events, then direction
`include "ots_consts.vh"

module ots_route #(
	parameter SRC_N = `OTS_SRC_N
)(
	// Clock and reset
	input wire clk_sys_i,
	input wire sys_rst_i,
	// Sources and settings
	input wire [SRC_N-1:0] src_active_i,
	input wire [SRC_N-1:0] src_enable_i,
	input wire inverse_i,
	// Result
	output wire any_active_o,
	output reg switch_q_o
);

	// Any enabled source active
	assign any_active_o = |(src_active_i & src_enable_i);

	// Registered switching level with direction applied
	always @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			switch_q_o <= `OTS_RST_BIT;
		else
			switch_q_o <= any_active_o ^ inverse_i;
	end

endmodule

// *** core/ots_bank.v ***
// Register bank and output forcing for the third output channel
`include "ots_consts.vh"

module ots_bank #(
	parameter SRC_N = `OTS_SRC_N,
	parameter AW = `OTS_ADDR_W,
	parameter DW = `OTS_DATA_W
)(
	// Clock and reset
	input wire clk_sys_i,
	input wire sys_rst_i,
	// Register access port
	input wire [AW-1:0] reg_addr_i,
	input wire reg_wr_i,
	input wire [DW-1:0] reg_wdata_i,
	input wire reg_rd_i,
	output reg [DW-1:0] reg_rdata_o,
	output reg reg_rvalid_o,
	output reg reg_err_o,
	// Internal events
	input wire limit_two_alarm_i,
	input wire limit_three_alarm_i,
	input wire count_end_i,
	input wire analog_input_one_fault_i,
	input wire analog_input_two_fault_i,
	input wire frequency_fault_i,
	input wire hours_preset_reached_i,
	input wire cycles_preset_reached_i,
	// Operating sense and forcing mode
	input wire output_inverse_i,
	input wire digital_force_mode_i,
	input wire analog_force_mode_i,
	// Controller analog value
	input wire [DW-1:0] analog_ctrl_value_i,
	// Outputs
	output reg digital_out_o,
	output reg [DW-1:0] analog_out_o
);

	// Enable registers, one bit each
	reg limit_two_route_enable_q;
	reg limit_three_route_enable_q;
	reg count_end_route_enable_q;
	reg input_one_fault_route_enable_q;
	reg input_two_fault_route_enable_q;
	reg frequency_fault_route_enable_q;
	reg hours_preset_route_enable_q;
	reg cycles_preset_route_enable_q;
	// Forcing registers
	reg digital_output_force_value_q;
	reg [DW-1:0] analog_output_force_value_q;
	// Read path next values
	reg [DW-1:0] rdata_d;
	reg err_d;
	reg hit_d;

	// Routing nets
	wire [SRC_N-1:0] src_active;
	wire [SRC_N-1:0] src_enable;
	wire route_level;
	wire wr_value_bit;

	// Signed clamp into the documented analog range
	function [DW-1:0] clamp_ao;
		input [DW-1:0] v;
		begin
			if ($signed(v) < $signed(`OTS_AO_MIN))
				clamp_ao = `OTS_AO_MIN;
			else if ($signed(v) > $signed(`OTS_AO_MAX))
				clamp_ao = `OTS_AO_MAX;
			else
				clamp_ao = v;
		end
	endfunction

	// Zero-extend a single flag to a register word
	function [DW-1:0] flag_word;
		input b;
		begin
			flag_word = {{(DW-1){1'b0}}, b};
		end
	endfunction

	// Address is one of the mapped words
	function is_mapped;
		input [AW-1:0] a;
		begin
			if (a == `OTS_ADR_LIM2_EN)
				is_mapped = 1'b1;
			else if (a == `OTS_ADR_LIM3_EN)
				is_mapped = 1'b1;
			else if (a == `OTS_ADR_CNT_EN)
				is_mapped = 1'b1;
			else if (a == `OTS_ADR_FLT1_EN)
				is_mapped = 1'b1;
			else if (a == `OTS_ADR_FLT2_EN)
				is_mapped = 1'b1;
			else if (a == `OTS_ADR_FRQ_EN)
				is_mapped = 1'b1;
			else if (a == `OTS_ADR_DO_STATE)
				is_mapped = 1'b1;
			else if (a == `OTS_ADR_DO_FORCE)
				is_mapped = 1'b1;
			else if (a == `OTS_ADR_AO_FORCE)
				is_mapped = 1'b1;
			else if (a == `OTS_ADR_AO_VALUE)
				is_mapped = 1'b1;
			else if (a == `OTS_ADR_HRS_EN)
				is_mapped = 1'b1;
			else if (a == `OTS_ADR_CYC_EN)
				is_mapped = 1'b1;
			else
				is_mapped = 1'b0;
		end
	endfunction

	// Address is one of the read-only status words
	function is_read_only;
		input [AW-1:0] a;
		begin
			if (a == `OTS_ADR_DO_STATE)
				is_read_only = 1'b1;
			else if (a == `OTS_ADR_AO_VALUE)
				is_read_only = 1'b1;
			else
				is_read_only = 1'b0;
		end
	endfunction

	// Write data bit shared by the single-flag words
	assign wr_value_bit = reg_wdata_i[0];

	// Gather sources and enables in a fixed bit order
	assign src_active[`OTS_SRC_LIM2] = limit_two_alarm_i;
	assign src_active[`OTS_SRC_LIM3] = limit_three_alarm_i;
	assign src_active[`OTS_SRC_CNT] = count_end_i;
	assign src_active[`OTS_SRC_FLT1] = analog_input_one_fault_i;
	assign src_active[`OTS_SRC_FLT2] = analog_input_two_fault_i;
	assign src_active[`OTS_SRC_FRQ] = frequency_fault_i;
	assign src_active[`OTS_SRC_HRS] = hours_preset_reached_i;
	assign src_active[`OTS_SRC_CYC] = cycles_preset_reached_i;

	// Enable bits in the same order
	assign src_enable[`OTS_SRC_LIM2] = limit_two_route_enable_q;
	assign src_enable[`OTS_SRC_LIM3] = limit_three_route_enable_q;
	assign src_enable[`OTS_SRC_CNT] = count_end_route_enable_q;
	assign src_enable[`OTS_SRC_FLT1] = input_one_fault_route_enable_q;
	assign src_enable[`OTS_SRC_FLT2] = input_two_fault_route_enable_q;
	assign src_enable[`OTS_SRC_FRQ] = frequency_fault_route_enable_q;
	assign src_enable[`OTS_SRC_HRS] = hours_preset_route_enable_q;
	assign src_enable[`OTS_SRC_CYC] = cycles_preset_route_enable_q;

	// Combine enabled sources and apply direction
	ots_route #(
		.SRC_N(SRC_N)
	) u_route (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.src_active_i(src_active),
		.src_enable_i(src_enable),
		.inverse_i(output_inverse_i),
		.any_active_o(),
		.switch_q_o(route_level)
	);

	// Routing enable words take bit 0 of the write data
	always @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			limit_two_route_enable_q <= `OTS_RST_BIT;
			limit_three_route_enable_q <= `OTS_RST_BIT;
			count_end_route_enable_q <= `OTS_RST_BIT;
			input_one_fault_route_enable_q <= `OTS_RST_BIT;
			input_two_fault_route_enable_q <= `OTS_RST_BIT;
			frequency_fault_route_enable_q <= `OTS_RST_BIT;
			hours_preset_route_enable_q <= `OTS_RST_BIT;
			cycles_preset_route_enable_q <= `OTS_RST_BIT;
		end
		else if (reg_wr_i)
		begin
			if (reg_addr_i == `OTS_ADR_LIM2_EN)
				limit_two_route_enable_q <= wr_value_bit;
			else if (reg_addr_i == `OTS_ADR_LIM3_EN)
				limit_three_route_enable_q <= wr_value_bit;
			else if (reg_addr_i == `OTS_ADR_CNT_EN)
				count_end_route_enable_q <= wr_value_bit;
			else if (reg_addr_i == `OTS_ADR_FLT1_EN)
				input_one_fault_route_enable_q <= wr_value_bit;
			else if (reg_addr_i == `OTS_ADR_FLT2_EN)
				input_two_fault_route_enable_q <= wr_value_bit;
			else if (reg_addr_i == `OTS_ADR_FRQ_EN)
				frequency_fault_route_enable_q <= wr_value_bit;
			else if (reg_addr_i == `OTS_ADR_HRS_EN)
				hours_preset_route_enable_q <= wr_value_bit;
			else if (reg_addr_i == `OTS_ADR_CYC_EN)
				cycles_preset_route_enable_q <= wr_value_bit;
		end
	end

	// Forcing words; read-only words ignore writes
	always @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			digital_output_force_value_q <= `OTS_RST_BIT;
			analog_output_force_value_q <= `OTS_RST_WORD;
		end
		else if (reg_wr_i)
		begin
			if (reg_addr_i == `OTS_ADR_DO_FORCE)
				digital_output_force_value_q <= wr_value_bit;
			else if (reg_addr_i == `OTS_ADR_AO_FORCE)
				analog_output_force_value_q <= clamp_ao(reg_wdata_i);
		end
	end

	// Digital output: forcing overrides the routed level
	always @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			digital_out_o <= `OTS_RST_BIT;
		else if (digital_force_mode_i)
			digital_out_o <= digital_output_force_value_q;
		else
			digital_out_o <= route_level;
	end

	// Analog output: forcing overrides the clamped controller value
	always @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			analog_out_o <= `OTS_RST_WORD;
		else if (analog_force_mode_i)
			analog_out_o <= analog_output_force_value_q;
		else
			analog_out_o <= clamp_ao(analog_ctrl_value_i);
	end

	// Read data decode
	always @*
	begin
		rdata_d = `OTS_RST_WORD;
		if (reg_addr_i == `OTS_ADR_LIM2_EN)
			rdata_d = flag_word(limit_two_route_enable_q);
		else if (reg_addr_i == `OTS_ADR_LIM3_EN)
			rdata_d = flag_word(limit_three_route_enable_q);
		else if (reg_addr_i == `OTS_ADR_CNT_EN)
			rdata_d = flag_word(count_end_route_enable_q);
		else if (reg_addr_i == `OTS_ADR_FLT1_EN)
			rdata_d = flag_word(input_one_fault_route_enable_q);
		else if (reg_addr_i == `OTS_ADR_FLT2_EN)
			rdata_d = flag_word(input_two_fault_route_enable_q);
		else if (reg_addr_i == `OTS_ADR_FRQ_EN)
			rdata_d = flag_word(frequency_fault_route_enable_q);
		else if (reg_addr_i == `OTS_ADR_HRS_EN)
			rdata_d = flag_word(hours_preset_route_enable_q);
		else if (reg_addr_i == `OTS_ADR_CYC_EN)
			rdata_d = flag_word(cycles_preset_route_enable_q);
		// Status and forcing words
		else if (reg_addr_i == `OTS_ADR_DO_STATE)
			rdata_d = flag_word(digital_out_o);
		else if (reg_addr_i == `OTS_ADR_DO_FORCE)
			rdata_d = flag_word(digital_output_force_value_q);
		else if (reg_addr_i == `OTS_ADR_AO_FORCE)
			rdata_d = analog_output_force_value_q;
		else if (reg_addr_i == `OTS_ADR_AO_VALUE)
			rdata_d = analog_out_o;
	end

	// Refusal decode: unmapped words and writes to read-only words
	always @*
	begin
		hit_d = is_mapped(reg_addr_i);
		err_d = 1'b0;
		if (reg_rd_i || reg_wr_i)
			err_d = ~hit_d;
		if (reg_wr_i && is_read_only(reg_addr_i))
			err_d = 1'b1;
	end

	// Answer pulses, one cycle after the strobe
	always @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			reg_rvalid_o <= 1'b0;
			reg_err_o <= 1'b0;
		end
		else
		begin
			reg_rvalid_o <= reg_rd_i;
			reg_err_o <= err_d;
		end
	end

	// Read data, held until the next read
	always @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			reg_rdata_o <= `OTS_RST_WORD;
		else if (reg_rd_i)
			reg_rdata_o <= rdata_d;
	end

endmodule

// *** testbench/ots_bank_properties.sv ***
// Port-level checks on the third output register bank
module ots_bank_properties (
	// Clock, reset and register port
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic reg_rvalid_o,
	input wire logic reg_err_o,
	// Events, modes and outputs
	input wire logic limit_two_alarm_i,
	input wire logic limit_three_alarm_i,
	input wire logic count_end_i,
	input wire logic analog_input_one_fault_i,
	input wire logic analog_input_two_fault_i,
	input wire logic frequency_fault_i,
	input wire logic hours_preset_reached_i,
	input wire logic cycles_preset_reached_i,
	input wire logic output_inverse_i,
	input wire logic digital_force_mode_i,
	input wire logic analog_force_mode_i,
	input wire logic [15:0] analog_ctrl_value_i,
	input wire logic digital_out_o,
	input wire logic [15:0] analog_out_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Any source raised
	wire src_any = limit_two_alarm_i | limit_three_alarm_i | count_end_i
		| analog_input_one_fault_i | analog_input_two_fault_i | frequency_fault_i
		| hours_preset_reached_i | cycles_preset_reached_i;
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (sys_rst_i);
	chk_read_answered: assert property (
		reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
	chk_state_read: assert property (
		(reg_rd_i && reg_addr_i == 16'h0410) ##1 $stable(digital_out_o)
		|-> reg_rdata_o == {15'h0000, digital_out_o}) else $error("state readback wrong");
	chk_ro_write: assert property (
		reg_wr_i && (reg_addr_i == 16'h0410 || reg_addr_i == 16'h0413) |=> reg_err_o)
		else $error("read-only write not refused");
	chk_enable_write: assert property (
		reg_wr_i && !reg_rd_i && reg_addr_i == 16'h0400 |=> !reg_err_o)
		else $error("enable write refused");
	chk_do_forced: assert property (
		(digital_force_mode_i && !reg_wr_i) [*3] |-> $stable(digital_out_o))
		else $error("forced digital output moved");
	chk_ao_forced: assert property (
		(analog_force_mode_i && !reg_wr_i) [*3] |-> $stable(analog_out_o))
		else $error("forced analog output moved");
	chk_ao_follow: assert property (
		!analog_force_mode_i && $signed(analog_ctrl_value_i) >= -1999
		&& $signed(analog_ctrl_value_i) <= 9999 |=> analog_out_o == $past(analog_ctrl_value_i))
		else $error("analog output not following");
	chk_idle_sense: assert property (
		(!digital_force_mode_i && !src_any && $stable(output_inverse_i)) [*3]
		|-> digital_out_o == output_inverse_i) else $error("idle output level wrong");
endmodule

bind ots_bank ots_bank_properties chk (.*);

// *** testbench/ots_master.sv ***
// Fieldbus master model on the register access port
module ots_master (
	input wire logic clk_sys_i,
	input wire logic [15:0] rdata_i,
	output logic [15:0] addr_o = 16'h0000,
	output logic wr_o = 1'b0,
	output logic [15:0] wdata_o = 16'h0000,
	output logic rd_o = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	// One write strobe; address and data scrambled while idle
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk_sys_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_sys_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask
	// One read strobe, data taken with the valid pulse
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge clk_sys_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_sys_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		@(posedge clk_sys_i);
		d = rdata_i;
	endtask
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench for the third output register bank
`include "ots_consts.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [15:0] addr, wdata, rdata, got;
	logic [15:0] aout, ctrl = 16'h0000;
	logic wr, rd, dout, inv = 1'b0, dfm = 1'b0, afm = 1'b0;
	logic [7:0] src = 8'h00, en;
	int bad_count = 0, n_tests = 0, seed = 97460, cyc = 0, i;
	logic [15:0] en_adr [8] = '{16'h0400, 16'h0401, 16'h0402, 16'h0408,
		16'h0409, 16'h040a, 16'h041f, 16'h0420};

	ots_master m (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .addr_o(addr), .wr_o(wr),
		.wdata_o(wdata), .rd_o(rd));
	ots_bank uut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
		.reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
		.reg_rvalid_o(), .reg_err_o(), .limit_two_alarm_i(src[0]),
		.limit_three_alarm_i(src[1]), .count_end_i(src[2]),
		.analog_input_one_fault_i(src[3]), .analog_input_two_fault_i(src[4]),
		.frequency_fault_i(src[5]), .hours_preset_reached_i(src[6]),
		.cycles_preset_reached_i(src[7]), .output_inverse_i(inv),
		.digital_force_mode_i(dfm), .analog_force_mode_i(afm),
		.analog_ctrl_value_i(ctrl), .digital_out_o(dout), .analog_out_o(aout));

	// Clock and hang guard
	always #4 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			bad_count++;
			summarize();
		end
	end

	function automatic logic [15:0] exp_ao(input logic [15:0] v);
		if ($signed(v) < -1999)
			return `OTS_AO_MIN;
		if ($signed(v) > 9999)
			return `OTS_AO_MAX;
		return v;
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic settle();
		repeat (4) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		repeat (8) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		for (i = 0; i < 8; i++)
		begin
			m.rd(en_adr[i], got);
			chk(got, 16'h0000);
		end
		m.wr(`OTS_ADR_AO_VALUE, 16'h1234);
		m.wr(`OTS_ADR_DO_STATE, 16'h0001);
		m.rd(`OTS_ADR_AO_VALUE, got);
		chk(got, 16'h0000);
		m.rd(16'h0403, got);
		chk(got, 16'h0000);
		m.rd(`OTS_ADR_DO_STATE, got);
		chk(got, 16'h0000);
		$display("test reset done");
		for (i = 0; i < 8; i++)
		begin
			m.wr(en_adr[i], 16'h0001);
			@(posedge clk_sys_i);
			src <= 8'h01 << i;
			settle();
			chk(dout, 1'b1);
			m.rd(`OTS_ADR_DO_STATE, got);
			chk(got, 16'h0001);
			m.wr(en_adr[i], 16'h0000);
			settle();
			chk(dout, 1'b0);
		end
		$display("test single sources done");
		for (i = 0; i < 40; i++)
		begin
			en = 8'($random(seed));
			for (int k = 0; k < 8; k++)
				m.wr(en_adr[k], {15'h0000, en[k]});
			@(posedge clk_sys_i);
			src <= 8'($random(seed));
			inv <= 1'($random(seed));
			ctrl <= 16'($random(seed) % 12000);
			settle();
			chk(dout, (|(en & src)) ^ inv);
			chk(aout, exp_ao(ctrl));
		end
		$display("test random routing done");
		m.wr(en_adr[0], 16'h0001);
		m.wr(`OTS_ADR_DO_FORCE, 16'h0001);
		m.wr(`OTS_ADR_AO_FORCE, 16'd12000);
		@(posedge clk_sys_i);
		dfm <= 1'b1;
		afm <= 1'b1;
		inv <= 1'b1;
		ctrl <= 16'h0000;
		src <= 8'hff;
		settle();
		chk(dout, 1'b1);
		chk(aout, `OTS_AO_MAX);
		m.wr(`OTS_ADR_DO_FORCE, 16'h0000);
		m.wr(`OTS_ADR_AO_FORCE, 16'hfc18);
		inv <= 1'b0;
		settle();
		chk(dout, 1'b0);
		chk(aout, 16'hfc18);
		m.rd(`OTS_ADR_AO_FORCE, got);
		chk(got, 16'hfc18);
		m.rd(`OTS_ADR_DO_STATE, got);
		chk(got, 16'h0000);
		$display("test forcing done");
		summarize();
	end
endmodule
